// [common/ivg_map.svh]
// register map, field positions, reset values and codes of the vector generator
//****************************************************************
// Summary of operation
// [R01] post highest pending unmasked level only
// [R02] core acknowledges with level on address bits
// [R03] recognise acknowledge, supply vector number
// [R04] vector is five base bits plus level
// [R05] one vector per level, seven in all
// [R06] higher level preempts, lower or equal waits
// [R07] software orders sources sharing one level
// [R08] mask blocks posting, pending stays readable
// [R09] software keeps vectors within user region
// [R10] unwritten base returns uninitialised vector
// [R11] mask bit one disables, zero enables
// [R12] edge requests cleared by writing one
// [R13] outside devices never supply a vector
// [R14] drive vector only during matching acknowledge
//****************************************************************
`ifndef IVG_MAP_SVH
`define IVG_MAP_SVH

//****************************************************************
// sizes
//****************************************************************
`define IVG_NUM_EXT 4
`define IVG_NUM_PER 4
`define IVG_NUM_SRC 8
`define IVG_NUM_EV 3
`define IVG_LVL_BITS 3
`define IVG_LVL_FIELD 4
`define IVG_ADDR_BITS 8

//****************************************************************
// byte offsets
//****************************************************************
`define IVG_ADDR_VECBASE 8'h00
`define IVG_ADDR_CTRL 8'h04
`define IVG_ADDR_MASK 8'h08
`define IVG_ADDR_PEND 8'h0c
`define IVG_ADDR_LEVEL 8'h10
`define IVG_ADDR_EVSTAT 8'h14
`define IVG_ADDR_EVMASK 8'h18
`define IVG_ADDR_STATE 8'h1c

//****************************************************************
// fields
//****************************************************************
`define IVG_VB_LSB 3
`define IVG_CTRL_POL_LSB 0
`define IVG_CTRL_EDGE_LSB 4
`define IVG_STATE_OE_BIT 3
`define IVG_EV_VEC 0
`define IVG_EV_UNINIT 1
`define IVG_EV_EDGE 2

//****************************************************************
// reset values and codes
//****************************************************************
`define IVG_MASK_RST 8'hff
`define IVG_LEVEL_RST 32'h0000_0000
`define IVG_UNINIT_VEC 8'h0f

`endif

// [common/ivg_pkg.sv]
// types shared by the vector generator and its bench
package ivg_pkg;
  `include "ivg_map.svh"

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`IVG_ADDR_BITS-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic valid;
    logic [`IVG_LVL_BITS-1:0] level;
  } iack_type;

  typedef struct packed {
    logic oe;
    logic [7:0] data;
  } vec_out_type;

  typedef struct packed {
    apb_rsp_type apbRsp;
    logic [4:0] vecBase;
    logic vbWritten;
    logic [`IVG_NUM_EXT-1:0] polarity;
    logic [`IVG_NUM_EXT-1:0] edgeMode;
    logic [`IVG_NUM_SRC-1:0] mask;
    logic [31:0] levels;
    logic [`IVG_NUM_EV-1:0] evStatus;
    logic [`IVG_NUM_EV-1:0] evMask;
    logic [`IVG_NUM_SRC-1:0] pend;
    logic [`IVG_NUM_EXT-1:0] prevActive;
    logic [`IVG_LVL_BITS-1:0] posted;
    vec_out_type vec;
    logic irq;
  } state_type;
endpackage

// [rtl/pin_sync.sv]
// three-stage synchroniser for request pins with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } sync_type;

  sync_type s_q;
  sync_type s_d;

  //****************************************************************
  // next state
  //****************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.s1 = pinIn;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // only stages two and three are compared; stage one may be metastable
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s_q.s2[i] == s_q.s3[i])
      begin
        s_d.held[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // request pins idle high on their pull-ups; zero here fakes an edge
      s_q <= '1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pinOut = s_q.held;
endmodule

// [rtl/level_interrupt_vector_gen.sv]
// level-ranked interrupt controller core with vector generation
`timescale 1ns/1ps
`include "ivg_map.svh"
module level_interrupt_vector_gen (
  input wire logic clock,
  input wire logic sys_rst,
  input ivg_pkg::apb_req_type apbReq,
  output ivg_pkg::apb_rsp_type apbRsp,
  input wire logic [`IVG_NUM_EXT-1:0] extIrqPin,
  input wire logic [`IVG_NUM_PER-1:0] periphReq,
  input ivg_pkg::iack_type iackReq,
  output ivg_pkg::vec_out_type vecOut,
  output logic [`IVG_LVL_BITS-1:0] postedLevel,
  output logic irq
);
  ivg_pkg::state_type s_q;
  ivg_pkg::state_type s_d;
  logic [`IVG_NUM_EXT-1:0] extSync;
  logic [`IVG_NUM_EXT-1:0] extActive;
  logic [`IVG_LVL_BITS-1:0] srcLevel [`IVG_NUM_SRC];

  //****************************************************************
  // pin synchronisers
  //****************************************************************
  pin_sync #(
    .WIDTH(`IVG_NUM_EXT)
  ) extSyncInst (
    .clock(clock),
    .sys_rst(sys_rst),
    .pinIn(extIrqPin),
    .pinOut(extSync)
  );

  //****************************************************************
  // per-source decode
  //****************************************************************
  for (genvar g = 0; g < `IVG_NUM_SRC; g++)
  begin : perSrc
    assign srcLevel[g] =
      s_q.levels[g*`IVG_LVL_FIELD +: `IVG_LVL_BITS];
    if (g < `IVG_NUM_EXT)
    begin : extPin
      // polarity one: high is active; zero: low is active
      assign extActive[g] = extSync[g] ~^ s_q.polarity[g];
    end
  end

  //****************************************************************
  // next state
  //****************************************************************
  always_comb
  begin
    logic setupPh;
    logic accessPh;
    logic wrEn;
    logic hit;
    logic [31:0] rdData;
    logic [`IVG_NUM_SRC-1:0] pendClr;
    logic [`IVG_NUM_EV-1:0] evSet;
    logic [`IVG_NUM_EV-1:0] evClr;
    logic [`IVG_LVL_BITS-1:0] best;
    logic ackHit;

    setupPh = 1'b0;
    accessPh = 1'b0;
    wrEn = 1'b0;
    hit = 1'b0;
    rdData = 32'h0000_0000;
    pendClr = '0;
    evSet = '0;
    evClr = '0;
    best = '0;
    ackHit = 1'b0;
    s_d = s_q;

    //**************************************************************
    // apb slave: ready is raised in setup so every access is one cycle
    //**************************************************************
    setupPh = apbReq.psel & ~apbReq.penable;
    accessPh = apbReq.psel & apbReq.penable & s_q.apbRsp.pready;
    unique case (apbReq.paddr)
      `IVG_ADDR_VECBASE:
      begin
        hit = 1'b1;
        rdData[7:`IVG_VB_LSB] = s_q.vecBase;
      end
      `IVG_ADDR_CTRL:
      begin
        hit = 1'b1;
        rdData[`IVG_CTRL_POL_LSB +: `IVG_NUM_EXT] = s_q.polarity;
        rdData[`IVG_CTRL_EDGE_LSB +: `IVG_NUM_EXT] = s_q.edgeMode;
      end
      `IVG_ADDR_MASK:
      begin
        hit = 1'b1;
        rdData[`IVG_NUM_SRC-1:0] = s_q.mask;
      end
      `IVG_ADDR_PEND:
      begin
        hit = 1'b1;
        rdData[`IVG_NUM_SRC-1:0] = s_q.pend; // [R08]
      end
      `IVG_ADDR_LEVEL:
      begin
        hit = 1'b1;
        rdData = s_q.levels;
      end
      `IVG_ADDR_EVSTAT:
      begin
        hit = 1'b1;
        rdData[`IVG_NUM_EV-1:0] = s_q.evStatus;
      end
      `IVG_ADDR_EVMASK:
      begin
        hit = 1'b1;
        rdData[`IVG_NUM_EV-1:0] = s_q.evMask;
      end
      `IVG_ADDR_STATE:
      begin
        hit = 1'b1;
        rdData[`IVG_LVL_BITS-1:0] = s_q.posted;
        rdData[`IVG_STATE_OE_BIT] = s_q.vec.oe;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    s_d.apbRsp.pready = setupPh;
    s_d.apbRsp.prdata = setupPh ? rdData : 32'h0000_0000;
    s_d.apbRsp.pslverr = setupPh & ~hit;

    // writes land only at the completing edge; unmapped ones are dropped
    wrEn = accessPh & apbReq.pwrite & hit;
    if (wrEn)
    begin
      unique case (apbReq.paddr)
        `IVG_ADDR_VECBASE:
        begin
          s_d.vecBase = apbReq.pwdata[7:`IVG_VB_LSB];
          s_d.vbWritten = 1'b1; // [R10]
        end
        `IVG_ADDR_CTRL:
        begin
          s_d.polarity =
            apbReq.pwdata[`IVG_CTRL_POL_LSB +: `IVG_NUM_EXT];
          s_d.edgeMode =
            apbReq.pwdata[`IVG_CTRL_EDGE_LSB +: `IVG_NUM_EXT];
        end
        `IVG_ADDR_MASK:
        begin
          s_d.mask = apbReq.pwdata[`IVG_NUM_SRC-1:0]; // [R11]
        end
        `IVG_ADDR_PEND:
        begin
          pendClr = apbReq.pwdata[`IVG_NUM_SRC-1:0]; // [R12]
        end
        `IVG_ADDR_LEVEL:
        begin
          s_d.levels = apbReq.pwdata;
        end
        `IVG_ADDR_EVSTAT:
        begin
          evClr = apbReq.pwdata[`IVG_NUM_EV-1:0];
        end
        `IVG_ADDR_EVMASK:
        begin
          s_d.evMask = apbReq.pwdata[`IVG_NUM_EV-1:0];
        end
        default:
        begin
          s_d.evMask = s_q.evMask;
        end
      endcase
    end

    //**************************************************************
    // request capture
    //**************************************************************
    for (int i = 0; i < `IVG_NUM_EXT; i++)
    begin
      if (s_q.edgeMode[i])
      begin
        // a new edge in the clearing cycle wins over the clear
        if (extActive[i] & ~s_q.prevActive[i])
        begin
          s_d.pend[i] = 1'b1; // [R12]
          evSet[`IVG_EV_EDGE] = 1'b1;
        end
        else if (pendClr[i])
        begin
          s_d.pend[i] = 1'b0; // [R12]
        end
      end
      else
      begin
        // level mode follows the pin; clears are ignored
        s_d.pend[i] = extActive[i]; // [R12]
      end
    end
    s_d.prevActive = extActive;
    for (int i = 0; i < `IVG_NUM_PER; i++)
    begin
      s_d.pend[`IVG_NUM_EXT+i] = periphReq[i]; // [R12]
    end

    //**************************************************************
    // ranking: sources sharing a level fold into one post
    //**************************************************************
    for (int i = 0; i < `IVG_NUM_SRC; i++)
    begin
      if (s_q.pend[i] & ~s_q.mask[i] & (srcLevel[i] > best))
      begin
        best = srcLevel[i]; // [R01] [R05] [R08] [R07]
      end
    end
    // a higher arrival replaces the post at once; the core's own mask
    // keeps equal or lower levels waiting
    s_d.posted = best; // [R06]

    //**************************************************************
    // acknowledge cycle
    //**************************************************************
    // R02: the core holds valid with the serviced level for the cycle
    ackHit = iackReq.valid & (iackReq.level == s_q.posted) &
      (s_q.posted != '0); // [R03] [R14]
    s_d.vec.oe = ackHit; // [R14] [R13]
    if (ackHit)
    begin
      if (s_q.vbWritten)
      begin
        s_d.vec.data = {s_q.vecBase, s_q.posted}; // [R04] [R05]
      end
      else
      begin
        s_d.vec.data = `IVG_UNINIT_VEC; // [R10]
      end
      if (~s_q.vec.oe)
      begin
        evSet[`IVG_EV_VEC] = 1'b1;
        evSet[`IVG_EV_UNINIT] = ~s_q.vbWritten;
      end
    end
    else
    begin
      s_d.vec.data = 8'h00;
    end

    //**************************************************************
    // event status: set beats clear
    //**************************************************************
    s_d.evStatus = (s_q.evStatus & ~evClr) | evSet;
    s_d.irq = |(s_d.evStatus & s_q.evMask);
  end

  //****************************************************************
  // state register
  //****************************************************************
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.mask <= `IVG_MASK_RST;
      s_q.levels <= `IVG_LEVEL_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign apbRsp = s_q.apbRsp;
  assign vecOut = s_q.vec;
  assign postedLevel = s_q.posted;
  assign irq = s_q.irq;
endmodule

// [tb/core_model.sv]
// processor core model that answers posted levels with acknowledge cycles
`timescale 1ns/1ps
module core_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [2:0] postedLevel,
  input ivg_pkg::vec_out_type vecOut,
  input wire logic rte,
  input wire logic badLvl,
  output ivg_pkg::iack_type iackReq
);
  //****************
  // acknowledge cycles
  //****************
  // no data output: only the device supplies a vector
  logic [2:0] ipl;
  logic [2:0] waitCnt;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      iackReq <= '0;
      ipl <= 3'h0;
      waitCnt <= 3'h0;
    end
    else if (iackReq.valid)
    begin
      waitCnt <= waitCnt + 3'h1;
      // a refused cycle is abandoned, else the model would hang
      if (vecOut.oe || waitCnt == 3'h6)
      begin
        // released level lines show the inverse, never a stale level
        iackReq <= {1'b0, ~iackReq.level};
        ipl <= vecOut.oe ? iackReq.level : ipl;
      end
    end
    else if (rte)
      ipl <= 3'h0;
    else if (postedLevel > ipl)
    begin
      iackReq <= {1'b1, postedLevel ^ {2'h0, badLvl}};
      waitCnt <= 3'h0;
    end
endmodule

// [tb/ivg_sva.sv]
// port assertions of the vector generator
`timescale 1ns/1ps
module ivg_sva (
  input wire logic clock,
  input wire logic sys_rst,
  input ivg_pkg::apb_req_type apbReq,
  input ivg_pkg::apb_rsp_type apbRsp,
  input wire logic [3:0] extIrqPin,
  input wire logic [3:0] periphReq,
  input ivg_pkg::iack_type iackReq,
  input ivg_pkg::vec_out_type vecOut,
  input wire logic [2:0] postedLevel,
  input wire logic irq
);
  //****************
  // properties
  //****************
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  logic ackOk;
  assign ackOk = iackReq.valid && iackReq.level == postedLevel
    && postedLevel != 3'h0;
  sequence s_match;
    ackOk;
  endsequence
  sequence s_start;
    vecOut.oe && !$past(vecOut.oe);
  endsequence
  property p_ack;
    s_match |=> vecOut.oe;
  endproperty
  property p_refuse;
    !ackOk |=> !vecOut.oe;
  endproperty
  property p_code;
    s_start |-> vecOut.data[2:0] == $past(postedLevel)
      || vecOut.data == 8'h0f;
  endproperty
  property p_zero;
    !vecOut.oe |-> vecOut.data == 8'h00;
  endproperty
  property p_steady;
    vecOut.oe ##1 vecOut.oe |-> $stable(vecOut.data);
  endproperty
  property p_posted;
    vecOut.oe |-> $past(postedLevel) != 3'h0;
  endproperty
  property p_end;
    s_start ##1 !iackReq.valid |=> !vecOut.oe;
  endproperty
  property p_idle;
    postedLevel == 3'h0 |=> !vecOut.oe;
  endproperty
  a_ack: assert property (p_ack) else $error("no vector");
  a_refuse: assert property (p_refuse) else $error("stray vector");
  a_code: assert property (p_code) else $error("bad code");
  a_zero: assert property (p_zero) else $error("bus not idle");
  a_steady: assert property (p_steady) else $error("vector moved");
  a_posted: assert property (p_posted) else $error("unposted");
  a_end: assert property (p_end) else $error("late release");
  a_idle: assert property (p_idle) else $error("idle vector");
endmodule

bind level_interrupt_vector_gen ivg_sva chkU (.clock(clock),
  .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
  .extIrqPin(extIrqPin), .periphReq(periphReq), .iackReq(iackReq),
  .vecOut(vecOut), .postedLevel(postedLevel), .irq(irq));

// [tb/testbench.sv]
// self-checking bench of the vector generator
`timescale 1ns/1ps
module testbench;
  logic clock;
  logic sys_rst;
  ivg_pkg::apb_req_type apbReq;
  ivg_pkg::apb_rsp_type apbRsp;
  logic [3:0] extIrqPin;
  logic [3:0] periphReq;
  ivg_pkg::iack_type iackReq;
  ivg_pkg::vec_out_type vecOut;
  logic [2:0] postedLevel;
  logic irq;
  logic rte;
  logic badLvl;
  logic oePrev;
  logic [7:0] expQ[$];
  logic [31:0] lfsr;
  logic [31:0] rdat;
  logic [31:0] want;
  logic rerr;
  logic [7:0] base;
  int badCount;
  int compares;
  int cyc;
  level_interrupt_vector_gen dut_u (.clock(clock), .sys_rst(sys_rst),
    .apbReq(apbReq), .apbRsp(apbRsp), .extIrqPin(extIrqPin),
    .periphReq(periphReq), .iackReq(iackReq), .vecOut(vecOut),
    .postedLevel(postedLevel), .irq(irq));
  core_model coreU (.clock(clock), .sys_rst(sys_rst),
    .postedLevel(postedLevel), .vecOut(vecOut), .rte(rte),
    .badLvl(badLvl), .iackReq(iackReq));
  //****************
  // tasks
  //****************
  function automatic logic [31:0] nextLfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic closeOut();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      badCount++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clock);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    @(posedge clock);
    while (apbRsp.pready !== 1'b1)
      @(posedge clock);
    rdat = apbRsp.prdata;
    rerr = apbRsp.pslverr;
    apbReq <= '0;
  endtask
  task automatic ret();
    @(posedge clock);
    rte <= 1'b1;
    @(posedge clock);
    rte <= 1'b0;
  endtask
  // the monitor pops the note when the vector appears
  task automatic ack(input logic [7:0] v);
    expQ.push_back(v);
    while (expQ.size() != 0)
      @(posedge clock);
  endtask
  //****************
  // vector monitor and timeout
  //****************
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      badCount++;
      closeOut();
    end
    if (vecOut.oe === 1'b1 && !oePrev)
    begin
      want = expQ.size() ? {24'h0, expQ.pop_front()} : 32'hx;
      chk({24'h0, vecOut.data}, want);
    end
    oePrev <= vecOut.oe === 1'b1;
  end
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    sys_rst = 1'b1;
    apbReq = '0;
    extIrqPin = 4'hf;
    periphReq = 4'h0;
    rte = 1'b0;
    badLvl = 1'b0;
    oePrev = 1'b0;
    lfsr = 32'h78e3;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk(rdat, 32'hff);
    apb(1'b0, 8'h20, 32'h0);
    chk({rdat[31:1], rerr}, 32'h1);
    apb(1'b1, 8'h10, 32'h0523_0006);
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b1, 8'h08, 32'h0);
    periphReq <= 4'h1;
    ack(8'h0f);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(rdat, 32'h3);
    apb(1'b1, 8'h14, 32'h7);
    @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    periphReq <= 4'h3;
    repeat (8) @(posedge clock);
    chk({29'h0, postedLevel}, 32'h3);
    apb(1'b1, 8'h00, 32'h40);
    periphReq <= 4'h7;
    ack(8'h45);
    apb(1'b1, 8'h08, 32'h40);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h70);
    chk({29'h0, postedLevel}, 32'h3);
    apb(1'b1, 8'h0c, 32'h70);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h70);
    badLvl <= 1'b1;
    ret();
    repeat (12) @(posedge clock);
    badLvl <= 1'b0;
    ack(8'h43);
    periphReq <= 4'h0;
    apb(1'b1, 8'h08, 32'h0);
    for (int l = 1; l < 8; l++)
    begin
      lfsr = nextLfsr(lfsr);
      // software keeps vector numbers in the user region
      base = lfsr[7:0] | 8'h40;
      apb(1'b1, 8'h10, {1'b0, l[2:0], 28'h0});
      apb(1'b1, 8'h00, {24'h0, base});
      ret();
      periphReq <= 4'h8;
      ack({base[7:3], l[2:0]});
      periphReq <= 4'h0;
    end
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat, {24'h0, base[7:3], 3'h0});
    extIrqPin <= 4'he;
    apb(1'b1, 8'h10, 32'h6);
    apb(1'b1, 8'h04, 32'h11);
    repeat (8) @(posedge clock);
    apb(1'b1, 8'h0c, 32'h1);
    extIrqPin <= 4'hf;
    repeat (6) @(posedge clock);
    extIrqPin <= 4'he;
    repeat (8) @(posedge clock);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h1);
    chk({29'h0, postedLevel}, 32'h6);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rdat, 32'h6);
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h0);
    closeOut();
  end
endmodule
